// file: rfal_field.sv
// Package of shared constants and the generic one-field storage/wire cell.
// Assumes a single clock, an active-low asynchronous field reset and a bus
// front end that turns each accepted write into a strobe with a bit mask.
`timescale 1ns/1ns
`default_nettype none

package rfal_pkg;
  localparam int unsigned REG_W = 32;
  localparam int unsigned ADR_W = 8;
  localparam logic [ADR_W-1:0] ADDR_AUTO     = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_EXPLICIT = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_STATUS   = 8'h08;
  localparam int unsigned ADR_LO = 2;

  // Fields of the auto-packed register, in instantiation order
  localparam int unsigned N_AUTO = 8;
  localparam int unsigned F_CTRL = 0;
  localparam int unsigned F_CFG  = 1;
  localparam int unsigned F_LIVE = 2;
  localparam int unsigned F_VER  = 3;
  localparam int unsigned F_CNT  = 4;
  localparam int unsigned F_CMD  = 5;
  localparam int unsigned F_ONCE = 6;
  localparam int unsigned F_KEEP = 7;
  localparam int unsigned FW [N_AUTO] = '{4, 4, 4, 4, 4, 4, 4, 4};
  localparam int unsigned AW = 4;

  localparam logic [AW-1:0] CTRL_RST = 4'hA;
  localparam logic [AW-1:0] CFG_RST  = 4'h3;
  localparam logic [AW-1:0] VER_VAL  = 4'h1; // Arbitrary value
  localparam logic [AW-1:0] CNT_RST  = 4'h0;
  localparam logic [AW-1:0] CMD_RST  = 4'h0;
  localparam logic [AW-1:0] ONCE_RST = 4'h0;

  // Fields of the explicitly placed register
  localparam int unsigned SCR_HI  = 15;
  localparam int unsigned SCR_LO  = 8;
  localparam int unsigned LOST_HI = 3;
  localparam int unsigned LOST_LO = 0;
  localparam int unsigned FLAG_LO = 20;
  localparam logic [SCR_HI-SCR_LO:0]   SCR_RST  = 8'hA5;
  localparam logic [LOST_HI-LOST_LO:0] LOST_RST = 4'h0;
  localparam logic                     FLAG_RST = 1'b1;

  // Status register bits
  localparam int unsigned ST_CFG_ERR  = 0;
  localparam int unsigned ST_ONCE_WR  = 1;

  // Low bit of an auto-placed field, either packing order
  function automatic int unsigned field_lsb(int unsigned idx, bit high_bit_first_packing);
    int unsigned used;
    used = 0;
    for (int unsigned i = 0; i < idx; i++) begin
      used += FW[i];
    end
    if (high_bit_first_packing) begin
      field_lsb = REG_W - used - FW[idx];
    end else begin
      field_lsb = used;
    end
  endfunction

  // Writable by the cpu and overwritten every clock by the core
  function automatic bit write_lost(bit cpu_wr, bit core_wr, bit core_has_we);
    write_lost = cpu_wr && core_wr && !core_has_we;
  endfunction
endpackage

module rfal_field #(
  parameter int unsigned       WIDTH       = 1,
  parameter bit                CPU_RD      = 1'b1,
  parameter bit                CPU_WR      = 1'b1,
  parameter bit                CORE_RD     = 1'b1,
  parameter bit                CORE_WR     = 1'b1,
  parameter bit                CORE_HAS_WE = 1'b0,
  parameter bit                WRITE_ONCE  = 1'b0,
  parameter bit                HAS_RESET   = 1'b1,
  parameter logic [WIDTH-1:0]  RESET_VAL   = '0
) (
  // Clock and field reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Cpu side
  input  wire logic             cpu_we,
  input  wire logic [WIDTH-1:0] cpu_wdata,
  input  wire logic [WIDTH-1:0] cpu_mask,
  output logic      [WIDTH-1:0] cpu_rdata,
  // Core side
  input  wire logic             core_we,
  input  wire logic [WIDTH-1:0] core_d,
  output logic      [WIDTH-1:0] q,
  output logic                  written
);
  // Only cpu-read-only fields without core read-write become wires
  localparam bit STORE = !(CPU_RD && !CPU_WR && !(CORE_RD && CORE_WR));

  if (STORE) begin : g_store
    logic [WIDTH-1:0] next_q;
    logic             next_written;

    always_comb begin
      next_q       = q;
      next_written = written;
      if (cpu_we && CPU_WR && !(WRITE_ONCE && written)) begin
        next_q       = (cpu_wdata & cpu_mask) | (q & ~cpu_mask);
        next_written = 1'b1;
      end
      // Core update placed last so it wins a collision
      if (CORE_WR && (!CORE_HAS_WE || core_we)) begin
        next_q = core_d;
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        written <= 1'b0;
      end else begin
        written <= next_written;
      end
    end

    if (HAS_RESET) begin : g_rst
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          q <= RESET_VAL;
        end else begin
          q <= next_q;
        end
      end
    end else begin : g_norst
      // No reset value: left uninitialised on purpose
      always_ff @(posedge clk) begin
        q <= next_q;
      end
    end
  end else begin : g_wire
    assign q       = CORE_WR ? core_d : RESET_VAL;
    assign written = 1'b0;
  end

  assign cpu_rdata = CPU_RD ? q : '0;
endmodule

`default_nettype wire

// file: rfal_top.sv
// Register bank with one auto-packed register, one explicitly placed one
// and a status word, reached over a classic Wishbone slave.
// Assumes core inputs are synchronous to clk; master holds requests until ack.
//
// Summary of operation
// - Low-bit-first: unplaced fields pack upward from bit 0 without gaps.
// - High-bit-first: unplaced fields pack downward from the top bit without gaps.
// - An explicit high:low range places the field exactly there.
// - The instantiation constant is loaded as reset value on field reset.
// - Without restriction a field is readable and writable by cpu and core.
// - Core-writable fields follow the core each clock, or only while enabled.
// - Cpu writes to core-overwritten fields are lost at the same clock; flagged error.
// - Write-once fields take the first cpu write after reset only.
// - Cpu read-write fields are always storage.
// - Cpu read-only, core read-write fields are storage.
// - Cpu read-only, core read-only or no-access fields are constant wires.
// - Cpu read-only, core write-only fields are wires read straight from core.
// - Cpu write-only, core readable fields are storage.
// - Reset value beats next value while field reset is active.
// - A field without reset value is never reset.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.

`timescale 1ns/1ns
`default_nettype none

module rfal_top
  import rfal_pkg::*;
#(
  parameter bit HIGH_BIT_FIRST = 1'b0
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [rfal_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [rfal_pkg::REG_W-1:0] wb_dat_i,
  output logic      [rfal_pkg::REG_W-1:0] wb_dat_o,
  output logic                         wb_ack_o,
  // Core inputs
  input  wire logic [rfal_pkg::AW-1:0] core_ctrl_d,
  input  wire logic                    core_ctrl_we,
  input  wire logic [rfal_pkg::AW-1:0] core_live_d,
  input  wire logic [rfal_pkg::AW-1:0] core_cnt_d,
  input  wire logic [rfal_pkg::LOST_HI-rfal_pkg::LOST_LO:0] core_lost_d,
  // Core outputs
  output logic      [rfal_pkg::AW-1:0] core_ctrl_q,
  output logic      [rfal_pkg::AW-1:0] core_cfg_q,
  output logic      [rfal_pkg::AW-1:0] core_cnt_q,
  output logic      [rfal_pkg::AW-1:0] core_cmd_q,
  output logic      [rfal_pkg::AW-1:0] core_once_q,
  output logic                         core_flag_q
);
  import rfal_pkg::*;

  localparam int unsigned L_CTRL = field_lsb(F_CTRL, HIGH_BIT_FIRST);
  localparam int unsigned L_CFG  = field_lsb(F_CFG,  HIGH_BIT_FIRST);
  localparam int unsigned L_LIVE = field_lsb(F_LIVE, HIGH_BIT_FIRST);
  localparam int unsigned L_VER  = field_lsb(F_VER,  HIGH_BIT_FIRST);
  localparam int unsigned L_CNT  = field_lsb(F_CNT,  HIGH_BIT_FIRST);
  localparam int unsigned L_CMD  = field_lsb(F_CMD,  HIGH_BIT_FIRST);
  localparam int unsigned L_ONCE = field_lsb(F_ONCE, HIGH_BIT_FIRST);
  localparam int unsigned L_KEEP = field_lsb(F_KEEP, HIGH_BIT_FIRST);
  localparam int unsigned SCR_W  = SCR_HI - SCR_LO + 1;
  localparam int unsigned LOST_W = LOST_HI - LOST_LO + 1;
  localparam bit LOST_CFG_ERR = write_lost(1'b1, 1'b1, 1'b0);

  // Bus handshake: ack one cycle after the request, write at the ack edge
  logic             req;
  logic             next_ack;
  logic [REG_W-1:0] next_dat;
  logic             wr_fire;
  logic             hit_auto;
  logic             hit_expl;
  logic             hit_stat;
  logic [REG_W-1:0] bmask;
  logic             we_auto;
  logic             we_expl;

  assign req      = wb_cyc_i && wb_stb_i;
  assign wr_fire  = req && wb_we_i && wb_ack_o;
  assign hit_auto = wb_adr_i[ADR_W-1:ADR_LO] == ADDR_AUTO[ADR_W-1:ADR_LO];
  assign hit_expl = wb_adr_i[ADR_W-1:ADR_LO] == ADDR_EXPLICIT[ADR_W-1:ADR_LO];
  assign hit_stat = wb_adr_i[ADR_W-1:ADR_LO] == ADDR_STATUS[ADR_W-1:ADR_LO];
  assign bmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign we_auto  = wr_fire && hit_auto;
  assign we_expl  = wr_fire && hit_expl;

  // Field cells and their read-back slices
  logic [AW-1:0]     rd_ctrl, rd_cfg, rd_live, rd_ver, rd_cnt, rd_cmd, rd_once, rd_keep;
  logic [SCR_W-1:0]  rd_scr;
  logic [LOST_W-1:0] rd_lost;
  logic              rd_flag;
  logic              once_written;

  rfal_field #(.WIDTH(AW), .CORE_HAS_WE(1'b1), .RESET_VAL(CTRL_RST)) u_ctrl (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_auto), .cpu_wdata(wb_dat_i[L_CTRL +: AW]),
    .cpu_mask(bmask[L_CTRL +: AW]), .cpu_rdata(rd_ctrl), .core_we(core_ctrl_we),
    .core_d(core_ctrl_d), .q(core_ctrl_q), .written());

  rfal_field #(.WIDTH(AW), .CORE_WR(1'b0), .RESET_VAL(CFG_RST)) u_cfg (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_auto), .cpu_wdata(wb_dat_i[L_CFG +: AW]),
    .cpu_mask(bmask[L_CFG +: AW]), .cpu_rdata(rd_cfg), .core_we(1'b0),
    .core_d('0), .q(core_cfg_q), .written());

  rfal_field #(.WIDTH(AW), .CPU_WR(1'b0), .CORE_RD(1'b0)) u_live (
    .clk(clk), .rst_b(rst_b), .cpu_we(1'b0), .cpu_wdata('0),
    .cpu_mask('0), .cpu_rdata(rd_live), .core_we(1'b0),
    .core_d(core_live_d), .q(), .written());

  rfal_field #(.WIDTH(AW), .CPU_WR(1'b0), .CORE_WR(1'b0), .RESET_VAL(VER_VAL)) u_ver (
    .clk(clk), .rst_b(rst_b), .cpu_we(1'b0), .cpu_wdata('0),
    .cpu_mask('0), .cpu_rdata(rd_ver), .core_we(1'b0),
    .core_d('0), .q(), .written());

  rfal_field #(.WIDTH(AW), .CPU_WR(1'b0), .RESET_VAL(CNT_RST)) u_cnt (
    .clk(clk), .rst_b(rst_b), .cpu_we(1'b0), .cpu_wdata('0),
    .cpu_mask('0), .cpu_rdata(rd_cnt), .core_we(1'b0),
    .core_d(core_cnt_d), .q(core_cnt_q), .written());

  rfal_field #(.WIDTH(AW), .CPU_RD(1'b0), .CORE_WR(1'b0), .RESET_VAL(CMD_RST)) u_cmd (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_auto), .cpu_wdata(wb_dat_i[L_CMD +: AW]),
    .cpu_mask(bmask[L_CMD +: AW]), .cpu_rdata(rd_cmd), .core_we(1'b0),
    .core_d('0), .q(core_cmd_q), .written());

  rfal_field #(.WIDTH(AW), .CORE_WR(1'b0), .WRITE_ONCE(1'b1), .RESET_VAL(ONCE_RST)) u_once (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_auto), .cpu_wdata(wb_dat_i[L_ONCE +: AW]),
    .cpu_mask(bmask[L_ONCE +: AW]), .cpu_rdata(rd_once), .core_we(1'b0),
    .core_d('0), .q(core_once_q), .written(once_written));

  // Scratch kept over reset on purpose: holds state for post-reset debug
  rfal_field #(.WIDTH(AW), .CORE_RD(1'b0), .CORE_WR(1'b0), .HAS_RESET(1'b0)) u_keep (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_auto), .cpu_wdata(wb_dat_i[L_KEEP +: AW]),
    .cpu_mask(bmask[L_KEEP +: AW]), .cpu_rdata(rd_keep), .core_we(1'b0),
    .core_d('0), .q(), .written());

  rfal_field #(.WIDTH(SCR_W), .CORE_RD(1'b0), .CORE_WR(1'b0), .RESET_VAL(SCR_RST)) u_scr (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_expl), .cpu_wdata(wb_dat_i[SCR_HI:SCR_LO]),
    .cpu_mask(bmask[SCR_HI:SCR_LO]), .cpu_rdata(rd_scr), .core_we(1'b0),
    .core_d('0), .q(), .written());

  // Cpu writes here never land, the core value wins at the same clock; reported in the status word
  rfal_field #(.WIDTH(LOST_W), .CORE_RD(1'b0), .RESET_VAL(LOST_RST)) u_lost (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_expl), .cpu_wdata(wb_dat_i[LOST_HI:LOST_LO]),
    .cpu_mask(bmask[LOST_HI:LOST_LO]), .cpu_rdata(rd_lost), .core_we(1'b0),
    .core_d(core_lost_d), .q(), .written());

  rfal_field #(.CORE_WR(1'b0), .RESET_VAL(FLAG_RST)) u_flag (
    .clk(clk), .rst_b(rst_b), .cpu_we(we_expl), .cpu_wdata(wb_dat_i[FLAG_LO]),
    .cpu_mask(bmask[FLAG_LO]), .cpu_rdata(rd_flag), .core_we(1'b0),
    .core_d(1'b0), .q(core_flag_q), .written());

  // Read multiplexer; unmapped addresses answer with zero
  always_comb begin
    next_ack = req && !wb_ack_o;
    next_dat = '0;
    if (next_ack && !wb_we_i) begin
      if (hit_auto) begin
        next_dat[L_CTRL +: AW] = rd_ctrl;
        next_dat[L_CFG  +: AW] = rd_cfg;
        next_dat[L_LIVE +: AW] = rd_live;
        next_dat[L_VER  +: AW] = rd_ver;
        next_dat[L_CNT  +: AW] = rd_cnt;
        next_dat[L_CMD  +: AW] = rd_cmd;
        next_dat[L_ONCE +: AW] = rd_once;
        next_dat[L_KEEP +: AW] = rd_keep;
      end else if (hit_expl) begin
        next_dat[SCR_HI:SCR_LO]   = rd_scr;
        next_dat[LOST_HI:LOST_LO] = rd_lost;
        next_dat[FLAG_LO]         = rd_flag;
      end else if (hit_stat) begin
        next_dat[ST_CFG_ERR] = LOST_CFG_ERR;
        next_dat[ST_ONCE_WR] = once_written;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // Checks; the read helpers mark the edge that takes a read request
  logic rd_auto_req;
  logic rd_expl_req;
  logic rd_stat_req;
  logic rd_none_req;
  assign rd_auto_req = req && !wb_ack_o && !wb_we_i && hit_auto;
  assign rd_expl_req = req && !wb_ack_o && !wb_we_i && hit_expl;
  assign rd_stat_req = req && !wb_ack_o && !wb_we_i && hit_stat;
  assign rd_none_req = req && !wb_ack_o && !wb_we_i && !hit_auto && !hit_expl && !hit_stat;

  a_ack_single: assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_latency: assert property (@(posedge clk) disable iff (!rst_b)
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  a_dat_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !wb_ack_o |-> wb_dat_o == '0)
    else $error("read data not zero outside ack");

  // Release edge excluded: the fields still sit in reset at that edge
  a_ctrl_we_update: assert property (@(posedge clk) disable iff (!rst_b)
    (rst_b && core_ctrl_we) |=> core_ctrl_q == $past(core_ctrl_d))
    else $error("enabled core update not taken");

  a_ctrl_hold: assert property (@(posedge clk) disable iff (!rst_b)
    (!core_ctrl_we && !we_auto) |=> $stable(core_ctrl_q))
    else $error("ctrl changed without any write");

  a_core_wins: assert property (@(posedge clk) disable iff (!rst_b)
    (core_ctrl_we && we_auto && bmask[L_CTRL]) |=> core_ctrl_q == $past(core_ctrl_d))
    else $error("cpu write beat core update");

  a_cnt_follows: assert property (@(posedge clk) disable iff (!rst_b)
    rst_b |=> core_cnt_q == $past(core_cnt_d))
    else $error("counter field not tracking core");

  a_cnt_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_auto_req |=> wb_dat_o[L_CNT +: AW] == $past(core_cnt_q))
    else $error("counter field not visible on read");

  a_lost_write: assert property (@(posedge clk) disable iff (!rst_b)
    we_expl ##1 1'b1 |-> u_lost.q == $past(core_lost_d))
    else $error("cpu write survived core overwrite");

  a_once_ignored: assert property (@(posedge clk) disable iff (!rst_b)
    (once_written && we_auto) |=> $stable(core_once_q))
    else $error("second write changed write-once field");

  a_once_first: assert property (@(posedge clk) disable iff (!rst_b)
    (!once_written && we_auto && (&bmask[L_ONCE +: AW])) |=>
      core_once_q == $past(wb_dat_i[L_ONCE +: AW]) && once_written)
    else $error("first write to write-once field lost");

  a_cfg_write: assert property (@(posedge clk) disable iff (!rst_b)
    (we_auto && (&bmask[L_CFG +: AW])) |=> core_cfg_q == $past(wb_dat_i[L_CFG +: AW]))
    else $error("cpu write to cfg field lost");

  a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !we_auto |=> $stable(core_cfg_q))
    else $error("cfg field changed without a cpu write");

  a_cmd_write: assert property (@(posedge clk) disable iff (!rst_b)
    (we_auto && (&bmask[L_CMD +: AW])) |=> core_cmd_q == $past(wb_dat_i[L_CMD +: AW]))
    else $error("cpu write to cmd field lost");

  a_cmd_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
    rd_auto_req |=> wb_dat_o[L_CMD +: AW] == '0)
    else $error("write-only field visible on read");

  a_live_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_auto_req |=> wb_dat_o[L_LIVE +: AW] == $past(core_live_d))
    else $error("live field not read from core");

  a_ver_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_auto_req |=> wb_dat_o[L_VER +: AW] == VER_VAL)
    else $error("constant field read wrong");

  a_flag_write: assert property (@(posedge clk) disable iff (!rst_b)
    (we_expl && bmask[FLAG_LO]) |=> core_flag_q == $past(wb_dat_i[FLAG_LO]))
    else $error("flag bit not written at its place");

  a_flag_read: assert property (@(posedge clk) disable iff (!rst_b)
    rd_expl_req |=> wb_dat_o[FLAG_LO] == $past(core_flag_q))
    else $error("flag bit not read at its place");

  a_status_once: assert property (@(posedge clk) disable iff (!rst_b)
    rd_stat_req |=> wb_dat_o[ST_ONCE_WR] == $past(once_written))
    else $error("status misreports write-once state");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    rd_none_req |=> wb_dat_o == '0)
    else $error("unmapped read returned data");

  a_reset_value: assert property (@(posedge clk)
    $rose(rst_b) |-> core_ctrl_q == CTRL_RST && core_flag_q == FLAG_RST && core_once_q == ONCE_RST)
    else $error("reset value not loaded");

  c_write_read: cover property (@(posedge clk) disable iff (!rst_b)
    we_auto ##[1:4] (wb_ack_o && !wb_we_i));
  c_once_twice: cover property (@(posedge clk) disable iff (!rst_b)
    once_written && we_auto);
  c_collision: cover property (@(posedge clk) disable iff (!rst_b)
    core_ctrl_we && we_auto);
  c_unmapped: cover property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o && !hit_auto && !hit_expl && !hit_stat);
  c_status_read: cover property (@(posedge clk) disable iff (!rst_b)
    rd_stat_req ##1 wb_ack_o);
endmodule

`default_nettype wire

// file: rfal_core_model.sv
// Core-side model of the register bank: drives the hardware-facing inputs.
// Assumes the bench calls drive(); values change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none

module rfal_core_model (
  // Clock
  input  wire logic                                       clk,
  // Values toward the bank
  output var logic  [rfal_pkg::AW-1:0]                    core_ctrl_d,
  output var logic                                        core_ctrl_we,
  output var logic  [rfal_pkg::AW-1:0]                    core_live_d,
  output var logic  [rfal_pkg::AW-1:0]                    core_cnt_d,
  output var logic  [rfal_pkg::LOST_HI-rfal_pkg::LOST_LO:0] core_lost_d
);
  import rfal_pkg::*;

  initial begin
    core_ctrl_d  = '0;
    core_ctrl_we = 1'h0;
    core_live_d  = '0;
    core_cnt_d   = '0;
    core_lost_d  = '0;
  end

  // Real core logic is synchronous, so never change mid-cycle
  task automatic drive(input logic [AW-1:0] ctrl, input logic we, input logic [AW-1:0] live,
                       input logic [AW-1:0] cnt, input logic [AW-1:0] lost);
    @(posedge clk);
    core_ctrl_d  <= ctrl;
    core_ctrl_we <= we;
    core_live_d  <= live;
    core_cnt_d   <= cnt;
    core_lost_d  <= lost;
  endtask
endmodule

`default_nettype wire

// file: tb_rfal_top.sv
// Self-checking bench for the register bank: Wishbone reads and writes,
// core updates, both packing orders and a second reset in mid-run.
// Assumes both bank instances answer every request with one ack pulse.
`timescale 1ns/1ns
`default_nettype none

module tb_rfal_top;
  import rfal_pkg::*;

  localparam int MAX_CYCLES = 3000;
  logic             clk    = 1'h0;
  logic             rst_b  = 1'h0;
  logic             cyc    = 1'h0;
  logic             stb    = 1'h0;
  logic             we     = 1'h0;
  logic [ADR_W-1:0] adr    = '0;
  logic [3:0]       sel    = '0;
  logic [REG_W-1:0] wdat   = '0;
  logic [REG_W-1:0] rdat_l;
  logic [REG_W-1:0] rdat_h;
  logic [REG_W-1:0] rd_l;
  logic [REG_W-1:0] rd_h;
  logic             ack_l;
  logic             ack_h;
  logic [AW-1:0]    ctrl_d, live_d, cnt_d, lost_d;
  logic             ctrl_we;
  logic [AW-1:0]    ctrl_q, cfg_q, cnt_q, cmd_q, once_q;
  logic             flag_q;
  int               num_errors = 0;
  int               n_compared = 0;
  int               cycles     = 0;
  wire logic [20:0] core_all = {ctrl_q, cfg_q, cnt_q, cmd_q, once_q, flag_q};

  always #10 clk = ~clk;

  rfal_core_model i_rfal_core_model (.clk(clk), .core_ctrl_d(ctrl_d), .core_ctrl_we(ctrl_we),
    .core_live_d(live_d), .core_cnt_d(cnt_d), .core_lost_d(lost_d));

  rfal_top #(.HIGH_BIT_FIRST(1'h0)) i_rfal_top (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat_l), .wb_ack_o(ack_l), .core_ctrl_d(ctrl_d), .core_ctrl_we(ctrl_we),
    .core_live_d(live_d), .core_cnt_d(cnt_d), .core_lost_d(lost_d), .core_ctrl_q(ctrl_q),
    .core_cfg_q(cfg_q), .core_cnt_q(cnt_q), .core_cmd_q(cmd_q), .core_once_q(once_q),
    .core_flag_q(flag_q));

  // Same traffic, opposite packing order
  rfal_top #(.HIGH_BIT_FIRST(1'h1)) i_rfal_top_hbf (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat_h), .wb_ack_o(ack_h), .core_ctrl_d(ctrl_d), .core_ctrl_we(ctrl_we),
    .core_live_d(live_d), .core_cnt_d(cnt_d), .core_lost_d(lost_d), .core_ctrl_q(),
    .core_cfg_q(), .core_cnt_q(), .core_cmd_q(), .core_once_q(), .core_flag_q());

  task automatic check(input string name, input logic [REG_W-1:0] seen, input logic [REG_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One classic cycle; request held until the edge that samples ack
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [3:0] s,
                    input logic [REG_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack_l !== 1'h1 && n < 20);
    rd_l = rdat_l;
    rd_h = rdat_h;
    check("ack", {ack_l, ack_h}, 32'h3);
    cyc <= 1'h0;
    stb <= 1'h0;
    we  <= 1'h0;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    i_rfal_core_model.drive(4'h0, 1'h0, 4'h6, 4'h9, 4'h5);
    // Keep field has no reset value, so its bits are masked
    wb(1'h0, ADDR_AUTO, 4'hF, '0);
    check("auto lsb", rd_l & 32'h0FFF_FFFF, 32'h0009_163A);
    check("auto msb", rd_h & 32'hFFFF_FFF0, 32'hA361_9000);
    @(negedge clk);
    check("core q", core_all, {4'hA, 4'h3, 4'h9, 4'h0, 4'h0, 1'h1});
    wb(1'h1, ADDR_AUTO, 4'hF, 32'h7654_3210);
    wb(1'h0, ADDR_AUTO, 4'hF, '0);
    check("auto lsb", rd_l, 32'h7609_1610);
    check("auto msb", rd_h, 32'h7661_9010);
    @(negedge clk);
    check("core q", core_all, {4'h0, 4'h1, 4'h9, 4'h5, 4'h6, 1'h1});
    wb(1'h0, ADDR_STATUS, 4'hF, '0);
    check("status lsb", rd_l, 32'h3);
    check("status msb", rd_h, 32'h3);
    // Second write must not touch the write-once field
    wb(1'h1, ADDR_AUTO, 4'h9, 32'h0800_0005);
    wb(1'h0, ADDR_AUTO, 4'hF, '0);
    check("auto lsb", rd_l, 32'h0609_1605);
    check("auto msb", rd_h, 32'h0861_9015);
    // Core enable held through a cpu write to the same field
    i_rfal_core_model.drive(4'h3, 1'h1, 4'h6, 4'h9, 4'h5);
    wb(1'h1, ADDR_AUTO, 4'h1, 32'h0000_0011);
    i_rfal_core_model.drive(4'hC, 1'h0, 4'h6, 4'hE, 4'h5);
    wb(1'h0, ADDR_AUTO, 4'hF, '0);
    check("auto lsb", rd_l, 32'h060E_1613);
    check("auto msb", rd_h, 32'h3861_E011);
    check("ctrl q", ctrl_q, 32'h3);
    wb(1'h0, ADDR_EXPLICIT, 4'hF, '0);
    check("explicit lsb", rd_l, 32'h0010_A505);
    check("explicit msb", rd_h, 32'h0010_A505);
    wb(1'h1, ADDR_EXPLICIT, 4'hF, 32'h0000_3C0A);
    wb(1'h0, ADDR_EXPLICIT, 4'hF, '0);
    check("explicit", rd_l, 32'h0000_3C05);
    check("explicit msb", rd_h, 32'h0000_3C05);
    check("flag q", flag_q, 32'h0);
    wb(1'h1, 8'h0C, 4'hF, 32'hFFFF_FFFF);
    wb(1'h0, 8'h0C, 4'hF, '0);
    check("unmapped", rd_l, 32'h0);
    // Second reset in mid-run
    @(posedge clk);
    rst_b <= 1'h0;
    @(negedge clk);
    check("core q", core_all, {4'hA, 4'h3, 4'h0, 4'h0, 4'h0, 1'h1});
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    wb(1'h0, ADDR_AUTO, 4'hF, '0);
    check("auto lsb", rd_l, 32'h000E_163A);
    check("auto msb", rd_h, 32'hA361_E001);
    wb(1'h0, ADDR_STATUS, 4'hF, '0);
    check("status", rd_l, 32'h1);
    check("status msb", rd_h, 32'h1);
    wb(1'h1, ADDR_AUTO, 4'h8, 32'h0200_0000);
    @(negedge clk);
    check("once q", once_q, 32'h2);
    complete_run();
  end
endmodule

`default_nettype wire
